// File: hdl/smbus_port_cfg.svh
/*
 Constants for the second SMBus port configuration block: register offset, bit positions,
 reset value, source codes and timing figures.
 Assumes it is included by bare name from the design modules.
*/
`ifndef SMBUS_PORT_CFG_SVH
`define SMBUS_PORT_CFG_SVH
// ==========================================================
// Register address and reset value.
`define CFG_REG_ADDR 8'hc1
`define CFG_REG_RESET 8'h00
// ==========================================================
// Field positions.
`define BIT_ENABLE 7
`define BIT_INHIBIT 6
`define BIT_BUSY 5
`define BIT_EXTEND 4
`define BIT_SCL_TOE 3
`define BIT_FREE_TOE 2
`define SRC_MSB 1
`define SRC_LSB 0
// ==========================================================
// Bit-rate source codes.
`define SRC_TIMER0 2'h0
`define SRC_TIMER5 2'h1
`define SRC_TIMER2_HIGH 2'h2
`define SRC_TIMER2_LOW 2'h3
// ==========================================================
// Bus free timeout: free after more than this many source periods.
`define FREE_PERIODS 4'ha
`endif

// File: hdl/smbus_port_pkg.sv
/*
 Types shared by the second SMBus port configuration block.
 Assumes the constants header is available on the include path.
*/
package smbus_port_pkg;
   // Decoded configuration fields.
   typedef struct packed {
      logic port_enable;
      logic target_inhibit;
      logic sda_timing_extend;
      logic scl_low_timeout_enable;
      logic bus_free_timeout_enable;
      logic [1:0] bit_rate_source_select;
   } port_cfg_t;
   // Timer overflow strobes from the timer block.
   typedef struct packed {
      logic timer0;
      logic timer5;
      logic timer2_high;
      logic timer2_low;
   } overflow_t;
   // Busy tracker states.
   typedef enum logic [1:0] {IDLE_ST, BUSY_ST} bus_state_t;
endpackage : smbus_port_pkg

// File: hdl/free_timer.sv
/*
 Bus free timeout counter: counts selected bit-rate source periods while both lines are high.
 Assumes synchronised line levels and a one-cycle source strobe on the same clock.
*/
`timescale 1ns/100ps
`include "smbus_port_cfg.svh"
module free_timer
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic lines_high,
   input wire logic src_tick,
   output logic timeout
);
   // Count of source periods seen with both lines high.
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   // Registered timeout pulse.
   logic timeout_reg;
   logic timeout_next;

   // ==========================================================
   // Next state.
   // The count restarts whenever either line drops, so only an unbroken high spell counts.
   always_comb
   begin
      cnt_next = cnt_reg;
      timeout_next = 1'b0;
      if (!run || !lines_high)
      begin
         cnt_next = 4'h0;
      end
      else if (src_tick)
      begin
         // One more than ten periods is needed, so fire on the eleventh tick.
         if (cnt_reg == `FREE_PERIODS)
         begin
            timeout_next = 1'b1; // RULE10
         end
         else
         begin
            cnt_next = cnt_reg + 4'h1;
         end
      end
   end

   // Registers.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cnt_reg <= 4'h0;
         timeout_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         timeout_reg <= timeout_next;
      end
   end

   assign timeout = timeout_reg;
endmodule : free_timer

// File: hdl/smbus_port_config.sv
/*
 Configuration and status register of the second SMBus port, plus the busy tracker, the
 SCL low timeout coupling to Timer 4, bus free detection and bit-rate source selection.
 Assumes an 8-bit special function register bus on clk, timer overflow strobes on clk,
 and raw line levels from the pins that are synchronised here.
*/
// Operation
// RULE1: Enable bit switches port on, lines watched
// RULE2: Inhibit suppresses slave event interrupts
// RULE3: Master interrupts pass regardless of inhibit
// RULE4: Busy flag set during bus transfer
// RULE5: Busy cleared by STOP or free timeout
// RULE6: Extend bit selects longer SDA setup/hold
// RULE7: Timeout enable reloads Timer 4 while SCL high
// RULE8: Split mode reloads only the high byte
// RULE9: Software sets 25 ms Timer 4 interrupt
// RULE10: Free after over ten idle source periods
// RULE11: Two bits select bit-rate clock source
// RULE12: Busy writes ignored, all bits reset zero
`timescale 1ns/100ps
`include "smbus_port_cfg.svh"
module smbus_port_config
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_page_f,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic port_data_line,
   input wire logic port_clock_line,
   input wire smbus_port_pkg::overflow_t overflow,
   input wire logic timer4_split,
   input wire logic slave_irq_req,
   input wire logic master_irq_req,
   output logic irq,
   output logic timer4_reload_low,
   output logic timer4_reload_high,
   output logic bit_rate_tick,
   output logic extend_timing,
   output logic monitor_on
);
   // ==========================================================
   // Storage.
   // Writable configuration fields.
   smbus_port_pkg::port_cfg_t cfg_reg;
   smbus_port_pkg::port_cfg_t cfg_next;
   // Busy tracker state.
   smbus_port_pkg::bus_state_t state_reg;
   smbus_port_pkg::bus_state_t state_next;
   // Two-stage synchronisers for the lines.
   logic sda_meta_reg;
   logic sda_sync_reg;
   logic scl_meta_reg;
   logic scl_sync_reg;
   // Previous synchronised levels for condition detection.
   logic sda_prev_reg;
   logic scl_prev_reg;
   // Registered outputs.
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic irq_reg;
   logic irq_next;
   logic rl_low_reg;
   logic rl_low_next;
   logic rl_high_reg;
   logic rl_high_next;
   logic tick_reg;
   logic tick_next;
   // Derived conditions.
   logic cfg_hit;
   logic start_seen;
   logic stop_seen;
   logic free_timeout;
   logic src_tick;
   logic busy;

   // Decode the selected overflow strobe.
   function automatic logic pick_source(input logic [1:0] sel,
                                        input smbus_port_pkg::overflow_t ov);
      case (sel)
         `SRC_TIMER0: pick_source = ov.timer0;
         `SRC_TIMER5: pick_source = ov.timer5;
         `SRC_TIMER2_HIGH: pick_source = ov.timer2_high;
         default: pick_source = ov.timer2_low;
      endcase
   endfunction : pick_source

   // ==========================================================
   // Combinational decode.
   // The register sits on page F only; page 0 holds the first port at the same address.
   assign cfg_hit = (sfr_addr == `CFG_REG_ADDR) && sfr_page_f;
   assign src_tick = pick_source(cfg_reg.bit_rate_source_select, overflow); // RULE11
   // START is SDA falling with SCL high; STOP is SDA rising with SCL high.
   assign start_seen = cfg_reg.port_enable && sda_prev_reg && !sda_sync_reg
                       && scl_sync_reg && scl_prev_reg; // RULE1
   assign stop_seen = cfg_reg.port_enable && !sda_prev_reg && sda_sync_reg
                      && scl_sync_reg && scl_prev_reg; // RULE1
   assign busy = (state_reg == smbus_port_pkg::BUSY_ST);

   // Free timeout counter, running only while the port and the option are on.
   free_timer u_free_timer
   (
      .clk(clk),
      .nrst(nrst),
      .run(cfg_reg.port_enable && cfg_reg.bus_free_timeout_enable),
      .lines_high(sda_sync_reg && scl_sync_reg),
      .src_tick(src_tick),
      .timeout(free_timeout)
   );

   // ==========================================================
   // Configuration register next value.
   always_comb
   begin
      cfg_next = cfg_reg;
      if (sfr_wr && cfg_hit)
      begin
         // The busy position of the write data is dropped here.
         cfg_next.port_enable = sfr_wdata[`BIT_ENABLE];
         cfg_next.target_inhibit = sfr_wdata[`BIT_INHIBIT];
         cfg_next.sda_timing_extend = sfr_wdata[`BIT_EXTEND];
         cfg_next.scl_low_timeout_enable = sfr_wdata[`BIT_SCL_TOE];
         cfg_next.bus_free_timeout_enable = sfr_wdata[`BIT_FREE_TOE];
         cfg_next.bit_rate_source_select = sfr_wdata[`SRC_MSB:`SRC_LSB]; // RULE12
      end
   end

   // ==========================================================
   // Busy tracker next state.
   // A START seen while busy keeps the state; a repeated START is still a transfer.
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         smbus_port_pkg::IDLE_ST:
         begin
            if (start_seen)
            begin
               state_next = smbus_port_pkg::BUSY_ST; // RULE4
            end
         end
         smbus_port_pkg::BUSY_ST:
         begin
            // A START in the same cycle as a clear wins, since a new transfer has begun.
            if (!cfg_reg.port_enable || ((stop_seen || free_timeout) && !start_seen))
            begin
               state_next = smbus_port_pkg::IDLE_ST; // RULE5
            end
         end
         default: state_next = smbus_port_pkg::IDLE_ST;
      endcase
   end

   // ==========================================================
   // Output next values.
   always_comb
   begin
      rdata_next = 8'h00;
      if (cfg_hit)
      begin
         rdata_next[`BIT_ENABLE] = cfg_reg.port_enable;
         rdata_next[`BIT_INHIBIT] = cfg_reg.target_inhibit;
         rdata_next[`BIT_BUSY] = busy; // RULE4
         rdata_next[`BIT_EXTEND] = cfg_reg.sda_timing_extend;
         rdata_next[`BIT_SCL_TOE] = cfg_reg.scl_low_timeout_enable;
         rdata_next[`BIT_FREE_TOE] = cfg_reg.bus_free_timeout_enable;
         rdata_next[`SRC_MSB:`SRC_LSB] = cfg_reg.bit_rate_source_select;
      end
      // Slave events are gated by the inhibit; master events never are.
      irq_next = cfg_reg.port_enable && ((slave_irq_req && !cfg_reg.target_inhibit) // RULE2
                 || master_irq_req); // RULE3
      // Timer 4 is held in reload while SCL is high and counts while it is low.
      // Software is expected to set a 25 ms overflow and reset the port from its handler.
      rl_high_next = cfg_reg.port_enable && cfg_reg.scl_low_timeout_enable
                     && scl_sync_reg; // RULE7
      rl_low_next = rl_high_next && !timer4_split; // RULE8
      tick_next = cfg_reg.port_enable && src_tick; // RULE11
   end

   // ==========================================================
   // All registers; synchronous active-low reset.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cfg_reg <= '0; // RULE12
         state_reg <= smbus_port_pkg::IDLE_ST;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         scl_prev_reg <= 1'b1;
         rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
         rl_low_reg <= 1'b0;
         rl_high_reg <= 1'b0;
         tick_reg <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         state_reg <= state_next;
         sda_meta_reg <= port_data_line;
         sda_sync_reg <= sda_meta_reg;
         scl_meta_reg <= port_clock_line;
         scl_sync_reg <= scl_meta_reg;
         sda_prev_reg <= sda_sync_reg;
         scl_prev_reg <= scl_sync_reg;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
         rl_low_reg <= rl_low_next;
         rl_high_reg <= rl_high_next;
         tick_reg <= tick_next;
      end
   end

   // Extended timing and monitoring follow the register directly; the timing engine reads them.
   assign sfr_rdata = rdata_reg;
   assign irq = irq_reg;
   assign timer4_reload_low = rl_low_reg;
   assign timer4_reload_high = rl_high_reg;
   assign bit_rate_tick = tick_reg;
   assign extend_timing = cfg_reg.sda_timing_extend; // RULE6
   assign monitor_on = cfg_reg.port_enable; // RULE1

   // ==========================================================
   // Assertions.
   a_busy_stop_clear: assert property (@(posedge clk) disable iff (!nrst)
      (busy && stop_seen) |=> !busy) else $error("busy not cleared by stop"); // RULE5
   a_busy_on_start: assert property (@(posedge clk) disable iff (!nrst)
      (start_seen) |=> busy) else $error("busy not set by start"); // RULE4
   a_inhibit_slave_irq: assert property (@(posedge clk) disable iff (!nrst)
      (cfg_reg.target_inhibit && slave_irq_req && !master_irq_req) |=> !irq)
      else $error("slave irq not inhibited"); // RULE2
   a_master_irq_pass: assert property (@(posedge clk) disable iff (!nrst)
      (cfg_reg.port_enable && master_irq_req) |=> irq)
      else $error("master irq lost"); // RULE3
   a_reload_scl_high: assert property (@(posedge clk) disable iff (!nrst)
      (cfg_reg.port_enable && cfg_reg.scl_low_timeout_enable && scl_sync_reg)
      |=> timer4_reload_high) else $error("no reload while scl high"); // RULE7
   a_split_high_only: assert property (@(posedge clk) disable iff (!nrst)
      timer4_split |=> !timer4_reload_low) else $error("low byte reloaded in split"); // RULE8
   a_busy_write_ignored: assert property (@(posedge clk) disable iff (!nrst)
      (sfr_wr && cfg_hit && sfr_wdata[`BIT_BUSY] && !busy && !start_seen) |=> !busy)
      else $error("busy written by software"); // RULE12
   a_free_clears_busy: assert property (@(posedge clk) disable iff (!nrst)
      (busy && free_timeout && !start_seen) |=> !busy)
      else $error("free timeout kept busy"); // RULE5
   a_source_tick: assert property (@(posedge clk) disable iff (!nrst)
      (cfg_reg.port_enable && cfg_reg.bit_rate_source_select == `SRC_TIMER5
       && overflow.timer5) |=> bit_rate_tick) else $error("wrong source"); // RULE11
endmodule : smbus_port_config

// File: sim/bus_party.sv
/*
 Far-side party on the second SMBus port: another master moving the data and clock lines.
 Assumes open-drain lines with pull-ups, so a released line reads high.
*/
`timescale 1ns/100ps
module bus_party
(
   input wire logic clk,
   output logic sda,
   output logic scl
);
   // ==========================================================
   // Line control.
   // Both lines start released; the pull-ups hold them high.
   initial
   begin
      sda = 1'b1;
      scl = 1'b1;
   end
   // A START: data falls while the clock is high, then the clock falls.
   task automatic start_cond();
      repeat (2) @(posedge clk);
      sda <= 1'b0;
      repeat (4) @(posedge clk);
      scl <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : start_cond
   // A STOP: the clock rises with data low, then data rises.
   task automatic stop_cond();
      sda <= 1'b0;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      sda <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : stop_cond
   // Both lines high again without a STOP: data rises while the clock is low.
   task automatic release_lines();
      sda <= 1'b1;
      repeat (4) @(posedge clk);
      scl <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : release_lines
endmodule : bus_party

// File: sim/smbus_port_config_tb.sv
/*
 Self-checking bench for the second SMBus port configuration register.
 Assumes the design, its package and header, and the bus party model are compiled first.
*/
`timescale 1ns/100ps
module smbus_port_config_tb;
   // ==========================================================
   // Signals.
   logic clk = 1'b0, nrst = 1'b0, sfr_page_f = 1'b0, sfr_wr = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd;
   smbus_port_pkg::overflow_t overflow = 4'h0;
   logic timer4_split = 1'b0, slave_irq_req = 1'b0, master_irq_req = 1'b0;
   logic irq, reload_low, reload_high, bit_rate_tick, extend_timing, monitor_on;
   logic sda, scl;
   int num_errors = 0, checks = 0, cycles = 0;
   smbus_port_config dut_u (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr),
      .sfr_page_f(sfr_page_f), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .port_data_line(sda), .port_clock_line(scl), .overflow(overflow),
      .timer4_split(timer4_split), .slave_irq_req(slave_irq_req),
      .master_irq_req(master_irq_req), .irq(irq), .timer4_reload_low(reload_low),
      .timer4_reload_high(reload_high), .bit_rate_tick(bit_rate_tick),
      .extend_timing(extend_timing), .monitor_on(monitor_on));
   bus_party party_u (.clk(clk), .sda(sda), .scl(scl));
   // ==========================================================
   // Clock, and a ceiling on cycles so a hang still ends in the report.
   initial
   begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors = num_errors + 1;
         close_out();
      end
   end
   // ==========================================================
   // Compare and bus tasks.
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks = checks + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8
   task automatic chk1(input string what, input logic exp, input logic got);
      chk8(what, {7'h00, exp}, {7'h00, got});
   endtask : chk1
   // One-cycle write strobe; the page flag picks whether the access counts.
   task automatic wr_reg(input logic [7:0] d, input logic page);
      @(posedge clk);
      sfr_addr <= 8'hc1;
      sfr_page_f <= page;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : wr_reg
   // Read data is registered, so it is taken at the falling edge after one rising edge.
   task automatic rd_reg();
      @(posedge clk);
      sfr_addr <= 8'hc1;
      sfr_page_f <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      rd = sfr_rdata;
   endtask : rd_reg
   // One overflow pulse, then the registered tick is sampled.
   task automatic pulse(input logic [3:0] v);
      @(posedge clk);
      overflow <= v;
      @(posedge clk);
      overflow <= 4'h0;
      @(negedge clk);
   endtask : pulse
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   // ==========================================================
   // Scenarios.
   task automatic t_reg();
      rd_reg();
      chk8("reset value", 8'h00, rd);
      wr_reg(8'hff, 1'b1);
      rd_reg();
      chk8("busy write ignored", 8'hdf, rd);
      chk1("monitor on", 1'b1, monitor_on);
      chk1("extend timing", 1'b1, extend_timing);
      wr_reg(8'h00, 1'b0);
      rd_reg();
      chk8("wrong page write", 8'hdf, rd);
      wr_reg(8'h00, 1'b1);
      settle(1);
      chk1("extend off", 1'b0, extend_timing);
      chk1("monitor off", 1'b0, monitor_on);
      $display("test reg done");
   endtask : t_reg
   task automatic t_irq();
      wr_reg(8'hc0, 1'b1);
      slave_irq_req <= 1'b1;
      settle(3);
      chk1("slave irq inhibited", 1'b0, irq);
      @(posedge clk);
      master_irq_req <= 1'b1;
      settle(3);
      chk1("master irq", 1'b1, irq);
      @(posedge clk);
      master_irq_req <= 1'b0;
      wr_reg(8'h80, 1'b1);
      settle(3);
      chk1("slave irq allowed", 1'b1, irq);
      @(posedge clk);
      slave_irq_req <= 1'b0;
      $display("test irq done");
   endtask : t_irq
   task automatic t_busy_reload();
      wr_reg(8'h88, 1'b1);
      settle(5);
      chk1("reload high", 1'b1, reload_high);
      chk1("reload low", 1'b1, reload_low);
      @(posedge clk);
      timer4_split <= 1'b1;
      settle(3);
      chk1("split low", 1'b0, reload_low);
      chk1("split high", 1'b1, reload_high);
      party_u.start_cond();
      settle(1);
      chk1("count high", 1'b0, reload_high);
      rd_reg();
      chk8("busy set", 8'ha8, rd);
      party_u.stop_cond();
      rd_reg();
      chk8("busy after stop", 8'h88, rd);
      @(posedge clk);
      timer4_split <= 1'b0;
      // A stuck transfer is cleared the way the Timer 4 handler would: port off, then on.
      party_u.start_cond();
      rd_reg();
      chk8("busy before handler", 8'ha8, rd);
      wr_reg(8'h08, 1'b1);
      wr_reg(8'h88, 1'b1);
      rd_reg();
      chk8("busy after handler", 8'h88, rd);
      party_u.release_lines();
      $display("test busy done");
   endtask : t_busy_reload
   task automatic t_free();
      // With the port off a START must go unseen.
      wr_reg(8'h04, 1'b1);
      party_u.start_cond();
      party_u.release_lines();
      rd_reg();
      chk8("start while off", 8'h04, rd);
      wr_reg(8'h84, 1'b1);
      party_u.start_cond();
      party_u.release_lines();
      repeat (10) pulse(4'h8);
      rd_reg();
      chk8("busy after ten", 8'ha4, rd);
      pulse(4'h8);
      settle(3);
      rd_reg();
      chk8("busy after eleven", 8'h84, rd);
      $display("test free done");
   endtask : t_free
   task automatic t_src();
      for (int c = 0; c < 4; c++)
      begin
         wr_reg(8'h80 | 8'(c), 1'b1);
         for (int k = 0; k < 4; k++)
         begin
            pulse(4'h8 >> k);
            chk1("rate tick", (c == k), bit_rate_tick);
         end
      end
      $display("test source done");
   endtask : t_src
   // ==========================================================
   // Verdict; the only place the run ends.
   task automatic close_out();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   // Main sequence after five reset cycles.
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reg();
      t_irq();
      t_busy_reload();
      t_free();
      t_src();
      close_out();
   end
endmodule : smbus_port_config_tb
